// ### scdiv_map.vh
`ifndef SCDIV_MAP_VH
`define SCDIV_MAP_VH

// ****************************************
// Register indexes (byte address = 4 x index)
// ****************************************
`define SCDIV_RATIO_IDX     16'hff5d
`define SCDIV_CTRL_IDX      16'hff60
`define SCDIV_WAIT_IDX      16'hff61
`define SCDIV_STAT_IDX      16'hff62

// ****************************************
// Reset values and fields
// ****************************************
`define SCDIV_RATIO_RESET   8'hfc
`define SCDIV_RATIO_ONES    6'h3f
`define SCDIV_SEL_LSB       0
`define SCDIV_SEL_MSB       1
`define SCDIV_CTRL_RESET    8'h02
`define SCDIV_CTRL_DUTY     0
`define SCDIV_CTRL_CLKOUT   1
`define SCDIV_WAIT_RESET    16'h2000
`define SCDIV_STAT_APPLIED  1
`define SCDIV_STAT_WAITING  2
`define SCDIV_STAT_PERIOD   8

// ****************************************
// Timing
// ****************************************
`define SCDIV_CLK_PERIOD_NS 40
`define SCDIV_SETTLE_NS     500000
`define SCDIV_SETTLE_CYC    ((`SCDIV_SETTLE_NS + `SCDIV_CLK_PERIOD_NS - 1) / `SCDIV_CLK_PERIOD_NS)
`define SCDIV_RESET_PULSE   10
`define SCDIV_MIN_SYS_HZ    1000000
`define SCDIV_PRESCALE_BITS 12

`endif

// ### scdiv_prescaler.v
`default_nettype none

// ****************************************
// Prescaler chain: ticks at sys/2 .. sys/4096
// ****************************************
module scdiv_prescaler #(
    parameter STAGES = 12
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire              halt,
    input  wire              sys_tick,
    output reg  [STAGES-1:0] stage_tick
);

    reg  [STAGES-1:0] count;
    wire [STAGES-1:0] next_stage_tick;

    // Cleared while halted so modules restart from a known phase
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {STAGES{1'b0}};
        end else if (halt) begin
            count <= {STAGES{1'b0}};
        end else if (sys_tick) begin
            count <= count + {{(STAGES-1){1'b0}}, 1'b1};
        end
    end

    genvar k;
    generate
        for (k = 0; k < STAGES; k = k + 1) begin : g_stage
            assign next_stage_tick[k] = sys_tick & ~halt & (&count[k:0]);
        end
    endgenerate

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_tick <= {STAGES{1'b0}};
        end else begin
            stage_tick <= next_stage_tick;
        end
    end

endmodule // scdiv_prescaler

`default_nettype wire

// ### scdiv_top.v
// The APB register port was chosen for this implementation.
`include "scdiv_map.vh"
`default_nettype none

// Operation
// - The divider divides the duty-adjusted clock by 1, 2, 4 or 8 as the two-bit select 00, 01, 10, 11 says.
// - The ratio register returns to 0xfc on reset and on entry to hardware standby.
// - Software standby leaves the ratio register untouched, so the ratio persists.
// - Bits 7 to 2 of the ratio register ignore writes and read as ones.
// - A ratio written while running takes effect without any reset.
// - The divided system clock can be driven onto the clock output pin.
// - A prescaler fed by the system clock makes ticks from sys/2 to sys/4096.
// - With a fast oscillator the duty cycle is corrected before the divider.
// - The prescaler and the standby exit wait run from the divided system clock and scale with the ratio.
// - The standby exit wait is counted in divided system clock cycles.
module scdiv_top #(
    parameter PERIOD_W = 8,
    parameter WAIT_W   = 16
) (
    input  wire                    core_clk,
    input  wire                    rstn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [17:0]             paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire                    external_clock_in,
    input  wire                    hw_standby_n,
    input  wire                    sw_standby,
    output reg                     sys_clk_out,
    output reg                     sys_clk_oe,
    output reg                     sys_tick,
    output wire [`SCDIV_PRESCALE_BITS-1:0] prescale_tick,
    output reg                     wake_waiting,
    output reg                     wake_done
);

    // ****************************************
    // Reset and pin synchronisers
    // ****************************************
    reg        rst_meta;
    reg        rst_sync_n;
    reg        hws_meta;
    reg        hws_sync_n;
    reg        ext_meta;
    reg        ext_sync;
    reg        ext_prev;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hws_meta   <= 1'b1;
            hws_sync_n <= 1'b1;
            ext_meta   <= 1'b0;
            ext_sync   <= 1'b0;
            ext_prev   <= 1'b0;
        end else begin
            hws_meta   <= hw_standby_n;
            hws_sync_n <= hws_meta;
            ext_meta   <= external_clock_in;
            ext_sync   <= ext_meta;
            ext_prev   <= ext_sync;
        end
    end

    wire ext_rise = ext_sync & ~ext_prev;
    wire ext_fall = ~ext_sync & ext_prev;
    wire hw_standby = ~hws_sync_n;

    // ****************************************
    // Registers
    // ****************************************
    reg  [1:0]        ratio_select;
    reg  [7:0]        ctrl;
    reg  [WAIT_W-1:0] wait_states;
    reg  [1:0]        applied_select;
    reg  [PERIOD_W-1:0] period;

    wire [15:0] reg_index = paddr[17:2];
    wire        hit_ratio = (reg_index == `SCDIV_RATIO_IDX);
    wire        hit_ctrl  = (reg_index == `SCDIV_CTRL_IDX);
    wire        hit_wait  = (reg_index == `SCDIV_WAIT_IDX);
    wire        hit_stat  = (reg_index == `SCDIV_STAT_IDX);
    wire        hit_any   = hit_ratio | hit_ctrl | hit_wait | hit_stat;
    wire        access    = psel & penable;
    wire        wr_ok     = access & pwrite & hit_any;

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    wire [7:0] ratio_view = {`SCDIV_RATIO_ONES, ratio_select};
    wire [7:0] ratio_reset = `SCDIV_RATIO_RESET;

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ratio_select <= 2'b00;
        end else if (hw_standby) begin
            ratio_select <= ratio_reset[`SCDIV_SEL_MSB:`SCDIV_SEL_LSB];
        end else if (wr_ok && hit_ratio) begin
            // Only the low two bits are storage; sw_standby is not looked at
            ratio_select <= pwdata[`SCDIV_SEL_MSB:`SCDIV_SEL_LSB];
        end
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl        <= `SCDIV_CTRL_RESET;
            wait_states <= `SCDIV_WAIT_RESET;
        end else begin
            if (wr_ok && hit_ctrl) begin
                ctrl <= {6'h00, pwdata[1:0]};
            end
            if (wr_ok && hit_wait) begin
                wait_states <= pwdata[WAIT_W-1:0];
            end
        end
    end

    always @* begin
        prdata = 32'h0000_0000;
        if (hit_ratio) begin
            prdata[7:0] = ratio_view;
        end else if (hit_ctrl) begin
            prdata[7:0] = ctrl;
        end else if (hit_wait) begin
            prdata[WAIT_W-1:0] = wait_states;
        end else if (hit_stat) begin
            prdata[`SCDIV_STAT_APPLIED:0]                    = applied_select;
            prdata[`SCDIV_STAT_WAITING]                      = wake_waiting;
            prdata[`SCDIV_STAT_PERIOD+PERIOD_W-1:`SCDIV_STAT_PERIOD] = period;
        end
    end

    // ****************************************
    // Duty adjustment
    // ****************************************
    // Measures the oscillator period in core cycles and rebuilds a
    // 50 % waveform; the oscillator must run well below core_clk / 4.
    reg  [PERIOD_W-1:0] period_cnt;
    reg  [PERIOD_W-1:0] phase_cnt;
    reg                 adj_clk;
    reg                 adj_edge;
    wire                duty_en = ctrl[`SCDIV_CTRL_DUTY];
    wire [PERIOD_W-1:0] half_period = {1'b0, period[PERIOD_W-1:1]};

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            period_cnt <= {PERIOD_W{1'b0}};
            period     <= {PERIOD_W{1'b0}};
        end else if (ext_rise) begin
            period     <= period_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
            period_cnt <= {PERIOD_W{1'b0}};
        end else if (period_cnt != {PERIOD_W{1'b1}}) begin
            period_cnt <= period_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            adj_clk   <= 1'b0;
            adj_edge  <= 1'b0;
            phase_cnt <= {PERIOD_W{1'b0}};
        end else if (duty_en) begin
            // High phase restarts at each rising edge, ends at half period
            adj_edge <= 1'b0;
            if (ext_rise) begin
                adj_clk   <= 1'b1;
                adj_edge  <= ~adj_clk;
                phase_cnt <= {{(PERIOD_W-1){1'b0}}, 1'b1};
            end else if (adj_clk && phase_cnt >= half_period && half_period != {PERIOD_W{1'b0}}) begin
                adj_clk  <= 1'b0;
                adj_edge <= 1'b1;
            end else if (phase_cnt != {PERIOD_W{1'b1}}) begin
                phase_cnt <= phase_cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
            end
        end else begin
            // Slow oscillator: its own waveform passes through
            adj_clk   <= ext_sync;
            adj_edge  <= ext_rise | ext_fall;
            phase_cnt <= {PERIOD_W{1'b0}};
        end
    end

    // ****************************************
    // Frequency divider
    // ****************************************
    // Half period of the system clock in adjusted-clock edges: 1, 2, 4, 8
    reg  [2:0] edge_cnt;
    reg  [3:0] half_edges;
    wire       half_done = ({1'b0, edge_cnt} == half_edges - 4'h1);

    always @* begin
        case (applied_select)
            2'b00: half_edges = 4'h1;
            2'b01: half_edges = 4'h2;
            2'b10: half_edges = 4'h4;
            2'b11: half_edges = 4'h8;
            default: half_edges = 4'h1;
        endcase
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sys_clk_out    <= 1'b0;
            sys_tick       <= 1'b0;
            edge_cnt       <= 3'h0;
            applied_select <= 2'b00;
        end else begin
            sys_tick <= 1'b0;
            if (adj_edge) begin
                if (half_done) begin
                    sys_clk_out <= ~sys_clk_out;
                    edge_cnt    <= 3'h0;
                    sys_tick    <= ~sys_clk_out;
                    if (sys_clk_out) begin
                        // Falling edge ends a full period: safe to switch
                        applied_select <= ratio_select;
                    end
                end else begin
                    edge_cnt <= edge_cnt + 3'h1;
                end
            end
        end
    end

    // ****************************************
    // Clock pin
    // ****************************************
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sys_clk_oe <= 1'b0;
        end else begin
            sys_clk_oe <= ctrl[`SCDIV_CTRL_CLKOUT] & ~hw_standby;
        end
    end

    // ****************************************
    // Standby exit wait
    // ****************************************
    reg              standby_prev;
    reg [WAIT_W-1:0] wait_cnt;

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            standby_prev <= 1'b0;
            wake_waiting <= 1'b0;
            wake_done    <= 1'b0;
            wait_cnt     <= {WAIT_W{1'b0}};
        end else begin
            standby_prev <= sw_standby;
            wake_done    <= 1'b0;
            if (sw_standby) begin
                wake_waiting <= 1'b0;
                wait_cnt     <= {WAIT_W{1'b0}};
            end else if (standby_prev) begin
                // Leaving standby: a zero wait finishes at once
                wake_waiting <= (wait_states != {WAIT_W{1'b0}});
                wake_done    <= (wait_states == {WAIT_W{1'b0}});
                wait_cnt     <= wait_states;
            end else if (wake_waiting && sys_tick) begin
                wait_cnt <= wait_cnt - {{(WAIT_W-1){1'b0}}, 1'b1};
                if (wait_cnt == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
                    wake_waiting <= 1'b0;
                    wake_done    <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Prescaler
    // ****************************************
    scdiv_prescaler #(
        .STAGES (`SCDIV_PRESCALE_BITS)
    ) u_prescaler (
        .clk        (core_clk),
        .rst_n      (rst_sync_n),
        .halt       (sw_standby | hw_standby),
        .sys_tick   (sys_tick),
        .stage_tick (prescale_tick)
    );

endmodule // scdiv_top

`default_nettype wire

// ### scdiv_top_props.sv
`include "scdiv_map.vh"
`default_nettype none

// ****************************************
// Port checks of the clock divider
// ****************************************
module scdiv_top_props (
    input wire logic                            core_clk,
    input wire logic                            rstn,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [17:0]                     paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic [31:0]                     prdata,
    input wire logic                            pready,
    input wire logic                            pslverr,
    input wire logic                            external_clock_in,
    input wire logic                            hw_standby_n,
    input wire logic                            sw_standby,
    input wire logic                            sys_clk_out,
    input wire logic                            sys_clk_oe,
    input wire logic                            sys_tick,
    input wire logic [`SCDIV_PRESCALE_BITS-1:0] prescale_tick,
    input wire logic                            wake_waiting,
    input wire logic                            wake_done
);
    timeunit 1ns;
    timeprecision 1ns;
    wire       acc;
    wire [15:0] idx;
    wire       is_div;
    wire       mapped;
    assign acc = psel && penable;
    assign idx = paddr[17:2];
    assign is_div = idx == `SCDIV_RATIO_IDX;
    assign mapped = is_div || idx == `SCDIV_CTRL_IDX || idx == `SCDIV_WAIT_IDX || idx == `SCDIV_STAT_IDX;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_ready; acc |-> pready; endproperty
    property p_tick_rise; sys_tick |-> sys_clk_out && !$past(sys_clk_out); endproperty
    property p_pre0; prescale_tick[0] |-> $past(sys_tick); endproperty
    property p_unmapped; acc && !mapped |-> pslverr && prdata == 32'h0; endproperty
    property p_ones; psel && is_div |-> prdata[31:2] == {24'h0, 6'h3f}; endproperty
    property p_hw_oe; !hw_standby_n [*4] |-> !sys_clk_oe; endproperty
    property p_hw_ratio; !hw_standby_n [*4] ##0 (psel && is_div) |-> prdata[1:0] == 2'h0; endproperty
    property p_wake; wake_done |=> !wake_done; endproperty
    // A runt high phase would upset every module on the divided clock
    property p_high; $rose(sys_clk_out) |=> sys_clk_out [*2]; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    a_tick_rise: assert property (p_tick_rise) else $error("tick without clock rise");
    a_pre0: assert property (p_pre0) else $error("prescaler tick without system tick");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    a_ones: assert property (p_ones) else $error("reserved ratio bits not ones");
    a_hw_oe: assert property (p_hw_oe) else $error("clock pin driven in hardware standby");
    a_hw_ratio: assert property (p_hw_ratio) else $error("ratio not cleared in hardware standby");
    a_wake: assert property (p_wake) else $error("wake pulse too long");
    a_high: assert property (p_high) else $error("short high phase");
    c_tick: cover property (sys_tick);
    c_wake: cover property (wake_done);
    c_err: cover property (acc && pslverr);
endmodule // scdiv_top_props

bind scdiv_top scdiv_top_props i_props (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_clock_in, .hw_standby_n, .sw_standby, .sys_clk_out, .sys_clk_oe, .sys_tick,
    .prescale_tick, .wake_waiting, .wake_done);

`default_nettype wire

// ### scdiv_osc_model.sv
`default_nettype none

// ****************************************
// Oscillator source, held high while stopped
// ****************************************
module scdiv_osc_model #(
    parameter int HI = 4,
    parameter int LO = 8
) (
    input  wire logic core_clk,
    input  wire logic hold_high,
    output var logic  osc
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial osc = 1'b0;
    // Uneven duty so the duty correction has work to do
    always @(posedge core_clk) begin
        if (hold_high) begin
            osc <= 1'b1;
            cnt <= 0;
        end else if (cnt >= (osc ? HI : LO) - 1) begin
            osc <= ~osc;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // scdiv_osc_model

`default_nettype wire

// ### scdiv_top_bench.sv
`include "scdiv_map.vh"
`default_nettype none

// ****************************************
// Bench of the clock divider
// ****************************************
module scdiv_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HI = 4;
    localparam int OSC = 12;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        hw_standby_n = 1'b1;
    logic        sw_standby = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] wd;
    logic [32:0] e;
    logic [1:0]  sel;
    logic [32:0] exp_q[$];
    wire  [31:0] prdata;
    wire  [11:0] prescale_tick;
    wire         pready, pslverr, osc, sys_clk_out, sys_clk_oe, sys_tick, wake_waiting, wake_done;
    int          bad_count = 0;
    int          comparisons = 0;
    int          n, i;

    always #20 core_clk = ~core_clk;

    scdiv_osc_model #(.HI(HI), .LO(OSC - HI)) i_osc (.core_clk, .hold_high(sw_standby || !hw_standby_n), .osc);
    scdiv_top i_dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .external_clock_in(osc), .hw_standby_n, .sw_standby, .sys_clk_out, .sys_clk_oe, .sys_tick,
        .prescale_tick, .wake_waiting, .wake_done);

    task check(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task apb(input logic wr, input logic [15:0] idx, input logic [31:0] d, input logic [32:0] exp);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        exp_q.push_back(exp);
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Spacing of pulses on the system tick (k < 0) or a prescaler tap
    task gap(input int k, input int n_exp);
        i = 0;
        n = 0;
        do begin @(posedge core_clk); #1; i++; end while ((k < 0 ? sys_tick : prescale_tick[k]) !== 1'b1 && i < 9000);
        do begin @(posedge core_clk); #1; n++; end while ((k < 0 ? sys_tick : prescale_tick[k]) !== 1'b1 && n < 9000);
        check(33'(n), 33'(n_exp));
    endtask

    task hi_len(input int n_exp);
        repeat (2) @(posedge sys_clk_out);
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (sys_clk_out === 1'b1 && n < 500);
        check(33'(n), 33'(n_exp));
    endtask

    always @(posedge core_clk) begin
        if (psel && penable && pready) begin
            e = exp_q.pop_front();
            if (pwrite)
                check({pslverr, 32'h0}, {e[32], 32'h0});
            else
                check({pslverr, prdata}, e);
        end
    end

    initial begin
        void'($urandom(32'h4f2d));
        // Model oscillator is stable at once: short hold stands in for the settle delay
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        apb(1'b0, `SCDIV_RATIO_IDX, 32'h0, 33'hfc);
        apb(1'b0, `SCDIV_CTRL_IDX, 32'h0, 33'h2);
        apb(1'b0, `SCDIV_WAIT_IDX, 32'h0, 33'h2000);
        apb(1'b0, 16'h0, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 16'h1, 32'h1, {1'b1, 32'h0});
        #1 check(sys_clk_oe, 1'b1);
        hi_len(HI);
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            wd = $urandom;
            wd[1:0] = sel;
            apb(1'b1, `SCDIV_RATIO_IDX, wd, 33'h0);
            apb(1'b0, `SCDIV_RATIO_IDX, 32'h0, {25'h0, 6'h3f, sel});
            repeat (2) @(posedge sys_tick);
            apb(1'b0, `SCDIV_STAT_IDX, 32'h0, {17'h0, 8'(OSC), 6'h0, sel});
            gap(-1, OSC << s);
        end
        apb(1'b1, `SCDIV_RATIO_IDX, 32'h0, 33'h0);
        // New ratio lands only at a period boundary; keep it out of the tap spacing
        repeat (2) @(posedge sys_tick);
        for (int k = 0; k < 3; k++)
            gap(k, OSC << (k + 1));
        apb(1'b1, `SCDIV_CTRL_IDX, 32'h3, 33'h0);
        hi_len(OSC / 2);
        apb(1'b1, `SCDIV_CTRL_IDX, 32'h1, 33'h0);
        repeat (3) @(posedge core_clk);
        #1 check(sys_clk_oe, 1'b0);
        apb(1'b1, `SCDIV_CTRL_IDX, 32'h3, 33'h0);
        apb(1'b1, `SCDIV_RATIO_IDX, 32'h2, 33'h0);
        apb(1'b1, `SCDIV_WAIT_IDX, 32'h3, 33'h0);
        @(posedge core_clk) sw_standby <= 1'b1;
        repeat (20) @(posedge core_clk);
        sw_standby <= 1'b0;
        n = 0;
        i = 0;
        do begin
            @(posedge core_clk);
            #1 i++;
            if (sys_tick === 1'b1 && wake_waiting === 1'b1)
                n++;
        end while (wake_done !== 1'b1 && i < 5000);
        check(33'(n), 33'h3);
        apb(1'b0, `SCDIV_RATIO_IDX, 32'h0, 33'hfe);
        @(posedge core_clk) hw_standby_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        apb(1'b0, `SCDIV_RATIO_IDX, 32'h0, 33'hfc);
        #1 check(sys_clk_oe, 1'b0);
        @(posedge core_clk) hw_standby_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        close_out;
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        close_out;
    end
endmodule // scdiv_top_bench

`default_nettype wire
